// ### spi_shift_pkg.sv
// Constants, types and helpers shared by the serial shifter files
package spi_shift_pkg;

  // ****************************************
  // Control and status field positions
  // ****************************************
  localparam int CTRL_IRQ_EN = 7;
  localparam int CTRL_ENABLE = 6;
  localparam int CTRL_ORDER = 5;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_SCK_IDLE_POLARITY = 3;
  localparam int CTRL_SCK_SAMPLE_PHASE = 2;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_RATE_LO = 0;
  localparam int STAT_DONE = 7;
  localparam int STAT_WRITE_COLLISION_FLAG = 6;
  localparam int STAT_DOUBLE = 0;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [3:0] PIN_SYNC_RESET = 4'h8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] EDGE_LAST = 4'hF;
  localparam int SCK_MIN_PHASE_CYCLES = 2;

  // ****************************************
  // Master clock generator states
  // ****************************************
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_WAIT = 2'b01,
    M_SHIFT = 2'b11
  } master_state_t;

  // Half SCK period minus one, in system clocks
  function automatic logic [5:0] half_period_m1(input logic dbl,
                                                input logic [1:0] rate);
    logic [5:0] r;
    case ({dbl, rate})
      3'h0: r = 6'h01;
      3'h1: r = 6'h07;
      3'h2: r = 6'h1F;
      3'h3: r = 6'h3F;
      3'h4: r = 6'h00;
      3'h5: r = 6'h03;
      3'h6: r = 6'h0F;
      default: r = 6'h1F;
    endcase
    return r;
  endfunction

endpackage

// ### pin_sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module pin_sync2 #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic ref_clk_i,        // System clock
  input wire logic reset_i,          // Async reset, active high
  input wire logic [WIDTH-1:0] d_i,  // Asynchronous inputs
  output logic [WIDTH-1:0] q_o       // Synchronised outputs
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ### rx_pair_buffer.sv
// Small shift-down FIFO holding received bytes
`timescale 1ns/10ps
module rx_pair_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk_i,            // System clock
  input wire logic reset_i,              // Async reset, active high
  input wire logic in_valid_i,           // Byte offered
  input wire logic [WIDTH-1:0] in_data_i, // Byte offered
  output logic in_ready_o,               // Room for one more
  output logic out_valid_o,              // Head entry valid
  output logic [WIDTH-1:0] out_data_o,   // Head entry
  input wire logic out_ready_i           // Reader takes head
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] vld;
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [DEPTH-1:0] next_vld;
  logic next_placed;
  wire pop = out_ready_i & vld[0];
  wire push = in_valid_i & in_ready_o;

  assign in_ready_o = ~vld[DEPTH-1];
  assign out_valid_o = vld[0];
  assign out_data_o = mem[0];

  always_comb begin
    next_mem = mem;
    next_vld = vld;
    next_placed = 1'b0;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_mem[i] = mem[i+1];
        next_vld[i] = vld[i+1];
      end
      next_vld[DEPTH-1] = 1'b0;
    end
    for (int i = 0; i < DEPTH; i++) begin
      if (push && !next_placed && !next_vld[i]) begin
        next_mem[i] = in_data_i;
        next_vld[i] = 1'b1;
        next_placed = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      vld <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      vld <= next_vld;
      mem <= next_mem;
    end
  end
endmodule

// ### spi_master_slave_shifter.sv
// Byte-wide full-duplex serial port, master or slave
`timescale 1ns/10ps
module spi_master_slave_shifter
  import spi_shift_pkg::*;
#(
  parameter int RX_DEPTH = 2
) (
  input wire logic ref_clk_i,          // System clock, 25 MHz
  input wire logic reset_i,            // Async reset, active high
  input wire logic serial_power_gate_i, // High powers the port down
  input wire logic ctrl_write_i,       // Control register write strobe
  input wire logic [7:0] ctrl_data_i,  // Control register write data
  input wire logic double_speed_i,     // Halve master SCK period
  input wire logic data_write_i,       // Shift data write strobe
  input wire logic [7:0] data_wdata_i, // Shift data write value
  input wire logic data_read_i,        // Shift data read strobe
  input wire logic status_read_i,      // Status register read strobe
  input wire logic irq_ack_i,          // Interrupt vector taken
  input wire logic rx_ready_i,         // Software pops a byte
  output logic rx_valid_o,             // Received byte waiting
  output logic [7:0] rx_data_o,        // Oldest received byte
  output logic [7:0] rx_last_o,        // Most recent received byte
  output logic [7:0] control_o,        // Control register
  output logic [7:0] status_o,         // Status register
  output logic irq_o,                  // Interrupt request
  input wire logic mosi_dir_i,         // User wants MOSI driven
  input wire logic miso_dir_i,         // User wants MISO driven
  input wire logic sck_dir_i,          // User wants SCK driven
  input wire logic ss_dir_i,           // User wants select driven
  input wire logic ss_level_i,         // Software select level
  input wire logic sck_i,              // SCK pin in
  output logic sck_o,                  // SCK pin out
  output logic sck_oe_o,               // SCK pin drive enable
  input wire logic mosi_i,             // MOSI pin in
  output logic mosi_o,                 // MOSI pin out
  output logic mosi_oe_o,              // MOSI pin drive enable
  input wire logic miso_i,             // MISO pin in
  output logic miso_o,                 // MISO pin out
  output logic miso_oe_o,              // MISO pin drive enable
  input wire logic ss_n_i,             // Select pin in, active low
  output logic ss_n_o,                 // Select pin out, active low
  output logic ss_n_oe_o               // Select pin drive enable
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] pins_s;
  logic sck_q;

  pin_sync2 #(.WIDTH(4), .RESET_VAL(PIN_SYNC_RESET)) u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .d_i({ss_n_i, miso_i, mosi_i, sck_i}),
    .q_o(pins_s)
  );

  wire sck_s = pins_s[0];
  wire mosi_s = pins_s[1];
  wire miso_s = pins_s[2];
  wire ss_n_s = pins_s[3];

  // ****************************************
  // State
  // ****************************************
  logic [7:0] serial_control_reg;
  logic [7:0] shift_data_reg;
  logic [7:0] tx_byte;
  logic [2:0] bit_cnt;
  logic [3:0] edge_cnt;
  logic [5:0] timer;
  logic out_bit;
  logic xfer_done_flag;
  logic write_collision_flag;
  logic clear_armed;
  logic ss_n_q;
  master_state_t state;
  master_state_t next_state;
  logic rx_in_ready;

  // ****************************************
  // Mode decode
  // ****************************************
  wire enabled = serial_control_reg[CTRL_ENABLE] & ~serial_power_gate_i;
  wire controller_select = serial_control_reg[CTRL_MASTER];
  wire is_master = enabled & controller_select;
  wire is_slave = enabled & ~controller_select;
  wire slave_sel = is_slave & ~ss_n_s;
  wire slave_drop = is_slave & ss_n_s & ~ss_n_q;
  wire sck_idle_polarity = serial_control_reg[CTRL_SCK_IDLE_POLARITY];
  wire sck_sample_phase = serial_control_reg[CTRL_SCK_SAMPLE_PHASE];
  wire lsb_first = serial_control_reg[CTRL_ORDER];
  wire xfer_irq_enable = serial_control_reg[CTRL_IRQ_EN];
  wire [1:0] rate = serial_control_reg[CTRL_RATE_HI:CTRL_RATE_LO];
  wire mode_fault = is_master & ~ss_dir_i & ~ss_n_s;

  // ****************************************
  // Edge detection
  // ****************************************
  wire s_rise = sck_s & ~sck_q;
  wire s_fall = ~sck_s & sck_q;
  wire s_lead = slave_sel & (sck_idle_polarity ? s_fall : s_rise);
  wire s_trail = slave_sel & (sck_idle_polarity ? s_rise : s_fall);
  wire m_tick = (state == M_SHIFT) & (timer == 6'h00);
  wire m_lead = m_tick & ~edge_cnt[0];
  wire m_trail = m_tick & edge_cnt[0];
  wire m_end = m_tick & (edge_cnt == EDGE_LAST);
  wire lead = is_master ? m_lead : s_lead;
  wire trail = is_master ? m_trail : s_trail;
  wire sample_edge = sck_sample_phase ? trail : lead;
  wire setup_edge = sck_sample_phase ? lead : trail;
  wire sample_bit = is_master ? miso_s : mosi_s;
  wire byte_complete = sample_edge & (bit_cnt == BIT_LAST);

  // ****************************************
  // Shift path and software access
  // ****************************************
  wire [7:0] shifted = lsb_first ? {sample_bit, shift_data_reg[7:1]}
                                 : {shift_data_reg[6:0], sample_bit};
  wire head = lsb_first ? shift_data_reg[0] : shift_data_reg[7];
  wire wr_head = lsb_first ? data_wdata_i[0] : data_wdata_i[7];
  wire busy = is_master ? (state != M_IDLE)
                        : (slave_sel & (bit_cnt != 3'h0));
  wire wr_ok = data_write_i & enabled & ~busy & ~sample_edge;
  wire wr_collide = data_write_i & ~wr_ok;
  wire data_access = data_write_i | data_read_i;
  wire flag_clear = clear_armed & data_access;
  wire done_set = m_end | (is_slave & byte_complete) | mode_fault;
  wire out_idle = is_master ? (state != M_SHIFT) : ~slave_sel;
  wire next_out = wr_ok ? wr_head
                : (setup_edge | out_idle) ? head : out_bit;
  wire next_done = done_set | (xfer_done_flag & ~irq_ack_i & ~flag_clear);
  wire next_write_collision_flag = wr_collide | (write_collision_flag & ~flag_clear);

  // ****************************************
  // Receive buffer
  // ****************************************
  rx_pair_buffer #(.WIDTH(8), .DEPTH(RX_DEPTH)) u_rxbuf (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .in_valid_i(byte_complete),
    .in_data_i(shifted),
    .in_ready_o(rx_in_ready),
    .out_valid_o(rx_valid_o),
    .out_data_o(rx_data_o),
    .out_ready_i(rx_ready_i)
  );

  // ****************************************
  // Master clock generator
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      M_IDLE: begin
        if (wr_ok && is_master) begin
          next_state = M_WAIT;
        end
      end
      M_WAIT: begin
        if (!is_master) begin
          next_state = M_IDLE;
        end else if (rx_in_ready) begin
          next_state = M_SHIFT;
        end
      end
      M_SHIFT: begin
        if (!is_master || m_end) begin
          next_state = M_IDLE;
        end
      end
      default: next_state = M_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= M_IDLE;
      timer <= 6'h00;
      edge_cnt <= 4'h0;
    end else begin
      state <= next_state;
      if (state != M_SHIFT || m_tick) begin
        timer <= half_period_m1(double_speed_i, rate);
      end else begin
        timer <= timer - 6'h01;
      end
      if (state != M_SHIFT) begin
        edge_cnt <= 4'h0;
      end else if (m_tick) begin
        edge_cnt <= edge_cnt + 4'h1;
      end
    end
  end

  // ****************************************
  // Shift register and bit counter
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_data_reg <= SHIFT_RESET;
      tx_byte <= SHIFT_RESET;
      bit_cnt <= 3'h0;
      sck_q <= 1'b0;
      ss_n_q <= 1'b1;
      rx_last_o <= SHIFT_RESET;
    end else begin
      sck_q <= sck_s;
      ss_n_q <= ss_n_s;
      if (wr_ok) begin
        shift_data_reg <= data_wdata_i;
        tx_byte <= data_wdata_i;
      end else if (slave_drop) begin
        shift_data_reg <= tx_byte;
      end else if (sample_edge) begin
        shift_data_reg <= shifted;
      end
      if (!enabled || (is_slave && ss_n_s) || state == M_WAIT) begin
        bit_cnt <= 3'h0;
      end else if (sample_edge) begin
        bit_cnt <= bit_cnt + 3'h1;
      end
      if (byte_complete) begin
        rx_last_o <= shifted;
      end
    end
  end

  // ****************************************
  // Control, flags and interrupt
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      serial_control_reg <= CTRL_RESET;
      xfer_done_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      clear_armed <= 1'b0;
      irq_o <= 1'b0;
      status_o <= STAT_RESET;
    end else begin
      if (ctrl_write_i) begin
        serial_control_reg <= ctrl_data_i;
      end
      if (mode_fault) begin
        serial_control_reg[CTRL_MASTER] <= 1'b0;
      end
      xfer_done_flag <= next_done;
      write_collision_flag <= next_write_collision_flag;
      if (status_read_i && (xfer_done_flag || write_collision_flag)) begin
        clear_armed <= 1'b1;
      end else if (data_access) begin
        clear_armed <= 1'b0;
      end
      irq_o <= next_done & xfer_irq_enable;
      status_o <= {next_done, next_write_collision_flag, 5'h00, double_speed_i};
    end
  end

  assign control_o = serial_control_reg;

  // ****************************************
  // Pin drivers
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_bit <= 1'b0;
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
      sck_o <= 1'b0;
      sck_oe_o <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_oe_o <= 1'b0;
      ss_n_o <= 1'b1;
      ss_n_oe_o <= 1'b0;
    end else begin
      out_bit <= next_out;
      mosi_o <= next_out;
      miso_o <= next_out;
      if (state != M_SHIFT) begin
        sck_o <= sck_idle_polarity;
      end else if (m_tick) begin
        sck_o <= ~sck_o;
      end
      sck_oe_o <= is_master & sck_dir_i;
      mosi_oe_o <= is_master & mosi_dir_i;
      miso_oe_o <= slave_sel & miso_dir_i;
      ss_n_o <= ss_level_i;
      ss_n_oe_o <= is_master & ss_dir_i;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  AST_POWER_GATE: assert property (
    serial_power_gate_i |=> !sck_oe_o && !mosi_oe_o && !miso_oe_o)
    else $error("port drives pins while powered down");
  AST_SCK_TOGGLE: assert property (
    state == M_SHIFT && m_tick && is_master |=> sck_o != $past(sck_o))
    else $error("master tick did not toggle SCK");
  AST_MASTER_END: assert property (
    m_end && is_master |=> state == M_IDLE && xfer_done_flag)
    else $error("master byte end not flagged");
  AST_IRQ: assert property (
    xfer_done_flag && xfer_irq_enable && !irq_ack_i && !flag_clear
      |=> irq_o)
    else $error("interrupt missing for set flag");
  AST_MISO_RELEASE: assert property (
    is_slave && ss_n_s |=> !miso_oe_o)
    else $error("unselected slave drives MISO");
  AST_SS_IGNORE: assert property (
    is_slave && ss_n_s |-> !sample_edge)
    else $error("slave shifted while deselected");
  AST_SLAVE_RESET: assert property (
    is_slave && ss_n_s |=> bit_cnt == 3'h0)
    else $error("slave bit count not reset");
  AST_SLAVE_DONE: assert property (
    is_slave && byte_complete |=> xfer_done_flag && rx_last_o == $past(shifted))
    else $error("slave byte not flagged");
  AST_COLLIDE: assert property (
    data_write_i && busy |=> write_collision_flag && $stable(tx_byte))
    else $error("write during shift not refused");
  AST_FAULT: assert property (
    mode_fault |=> !serial_control_reg[CTRL_MASTER] && xfer_done_flag)
    else $error("mode fault not handled");
  AST_SCK_IDLE: assert property (
    state == M_IDLE ##1 state == M_IDLE |-> sck_o == $past(sck_idle_polarity))
    else $error("idle SCK level wrong");

  COV_MASTER_BYTE: cover property (m_end && is_master);
  COV_SLAVE_BYTE: cover property (is_slave && byte_complete);
  COV_FAULT: cover property (mode_fault);
  COV_BACK_TO_BACK: cover property (m_end ##[1:20] state == M_SHIFT);

endmodule

// ### spi_far_end.sv
// Far-side serial device: slave in any mode, master in mode zero
`timescale 1ns/10ps
module spi_far_end (
  input wire logic clk_i,       // Bench clock, paces idle noise
  input wire logic sck_idle_polarity_i,      // Slave clock idle level
  input wire logic sck_sample_phase_i,      // Slave clock phase
  input wire logic [7:0] tx_i,  // Byte returned as slave
  input wire logic sck_i,       // Resolved SCK line
  input wire logic mosi_i,      // Resolved MOSI line
  input wire logic miso_i,      // Resolved MISO line
  input wire logic ss_n_i,      // Resolved select line
  output logic sck_o,           // SCK while leading
  output logic mosi_o,          // MOSI while leading
  output logic miso_o,          // MISO while answering
  output logic ss_n_o,          // Select while leading
  output logic [7:0] rx_o,      // Last bits taken as slave
  output logic [7:0] cnt_o      // Sample edges seen as slave
);
  logic [7:0] sh;
  logic started;
  logic noise;
  logic framing;
  logic mbit;
  initial begin
    {sh, rx_o, cnt_o} = '0;
    {started, noise, framing, mbit, sck_o} = '0;
    ss_n_o = 1'h1;
  end
  // ********
  // Slave side
  // ********
  // Released lines toggle so that no stale bit can be read
  always @(posedge clk_i) noise <= ~noise;
  assign miso_o = ss_n_i ? noise : sh[7];
  assign mosi_o = framing ? mbit : ~noise;
  always @(negedge ss_n_i) begin
    sh = tx_i;
    started = 1'h0;
  end
  always @(sck_i) begin
    if (!ss_n_i && (sck_i ^ sck_idle_polarity_i ^ sck_sample_phase_i)) begin
      rx_o = {rx_o[6:0], mosi_i};
      cnt_o = cnt_o + 8'h01;
      started = 1'h1;
    end else if (!ss_n_i && started) begin
      sh = {sh[6:0], sh[7]};
    end
  end
  // ********
  // Master side, SCK period 320 ns
  // ********
  task automatic lead(input logic [7:0] tx, input int n, input logic sel,
                      output logic [7:0] rx);
    // Move off the sampling edge so the pins never race the clock
    @(negedge clk_i);
    rx = 8'h00;
    framing = 1'h1;
    mbit = tx[7];
    ss_n_o = ~sel;
    #320;
    for (int i = 0; i < n; i++) begin
      mbit = tx[7 - i];
      #160 sck_o = 1'h1;
      rx = {rx[6:0], miso_i};
      #160 sck_o = 1'h0;
    end
    #320 ss_n_o = 1'h1;
    framing = 1'h0;
    @(posedge clk_i);
  endtask
endmodule

// ### tb_spi_master_slave_shifter.sv
// Self-checking bench for the byte-wide master or slave serial port
`timescale 1ns/10ps
module tb_spi_master_slave_shifter
  import spi_shift_pkg::*;
;
  logic clk, rst, gate, cwr, dwr, drd, srd, ack, rrdy, dbl;
  logic mosi_dir, miso_dir, sck_dir, ss_dir, sslv, sck_idle_polarity, sck_sample_phase;
  logic [7:0] cdat, wdat, tx, rxd, rxl, ctl, st, frx, fcnt;
  logic rxv, irq, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, ssn, ssn_oe;
  logic f_sck, f_mosi, f_miso, f_ssn;
  int err_total;
  int checks_done;
  wire sck_w = sck_oe ? sck : f_sck;
  wire mosi_w = mosi_oe ? mosi : f_mosi;
  wire miso_w = miso_oe ? miso : f_miso;
  wire ss_w = ssn_oe ? ssn : f_ssn;

  spi_master_slave_shifter u_dut (
    .ref_clk_i(clk), .reset_i(rst), .serial_power_gate_i(gate),
    .ctrl_write_i(cwr), .ctrl_data_i(cdat), .double_speed_i(dbl),
    .data_write_i(dwr), .data_wdata_i(wdat), .data_read_i(drd),
    .status_read_i(srd), .irq_ack_i(ack), .rx_ready_i(rrdy),
    .rx_valid_o(rxv), .rx_data_o(rxd), .rx_last_o(rxl),
    .control_o(ctl), .status_o(st), .irq_o(irq),
    .mosi_dir_i(mosi_dir), .miso_dir_i(miso_dir), .sck_dir_i(sck_dir),
    .ss_dir_i(ss_dir), .ss_level_i(sslv), .sck_i(sck_w), .sck_o(sck),
    .sck_oe_o(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi), .mosi_oe_o(mosi_oe),
    .miso_i(miso_w), .miso_o(miso), .miso_oe_o(miso_oe), .ss_n_i(ss_w),
    .ss_n_o(ssn), .ss_n_oe_o(ssn_oe)
  );
  spi_far_end u_far (
    .clk_i(clk), .sck_idle_polarity_i(sck_idle_polarity), .sck_sample_phase_i(sck_sample_phase), .tx_i(tx), .sck_i(sck_w),
    .mosi_i(mosi_w), .miso_i(miso_w), .ss_n_i(ss_w), .sck_o(f_sck),
    .mosi_o(f_mosi), .miso_o(f_miso), .ss_n_o(f_ssn), .rx_o(frx),
    .cnt_o(fcnt)
  );
  // ********
  // Helpers
  // ********
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic checkb(input string what, input logic exp, input logic got);
    check(what, {7'h0, exp}, {7'h0, got});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic set_ctrl(input logic [7:0] v);
    cwr <= 1'h1;
    cdat <= v;
    @(posedge clk);
    cwr <= 1'h0;
    tick(3);
  endtask
  task automatic put(input logic [7:0] v);
    dwr <= 1'h1;
    wdat <= v;
    @(posedge clk);
    dwr <= 1'h0;
    @(posedge clk);
  endtask
  // 0 status read, 1 data read, 2 vector taken, 3 pop a byte
  task automatic poke(input int k);
    srd <= (k == 0);
    drd <= (k == 1);
    ack <= (k == 2);
    rrdy <= (k == 3);
    @(posedge clk);
    {srd, drd, ack, rrdy} <= 4'h0;
    tick(2);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (st[STAT_DONE] !== 1'h1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    checkb("done flag", 1'h1, st[STAT_DONE]);
  endtask
  task automatic reselect();
    sslv <= 1'h1;
    tick(4);
    sslv <= 1'h0;
    tick(4);
  endtask
  // ********
  // Scenarios
  // ********
  task automatic test_power();
    logic [7:0] c0;
    gate <= 1'h1;
    set_ctrl(8'hD1);
    c0 = fcnt;
    put(8'hA5);
    tick(300);
    checkb("gated sck drive", 1'h0, sck_oe);
    check("gated edges", c0, fcnt);
    checkb("gated done", 1'h0, st[STAT_DONE]);
    gate <= 1'h0;
    poke(0);
    poke(1);
    check("status cleared", 8'h00, st);
    $display("test_power done");
  endtask
  task automatic test_modes();
    logic [7:0] c0;
    logic [1:0] rt;
    int hp;
    time t0;
    for (int m = 0; m < 4; m++) begin
      sck_idle_polarity <= m[1];
      sck_sample_phase <= m[0];
      dbl <= (m == 3);
      tx <= 8'(8'h3A + m);
      // Rate codes with half periods of 8, 32, 64 and 4 clocks
      rt = (m == 0 || m == 3) ? 2'h1 : 2'(m + 1);
      hp = (m == 0) ? 8 : (m == 1) ? 32 : (m == 2) ? 64 : 4;
      set_ctrl({4'hD, m[1:0], rt});
      checkb("sck idle", m[1], sck);
      reselect();
      c0 = fcnt;
      t0 = $time;
      put(8'(8'hC5 ^ m));
      wait_done();
      checks_done++;
      if ($time - t0 != 40 * (16 * hp + 3)) begin
        err_total++;
        $display("wrong value frame time: expected %0d, seen %0d",
                 40 * (16 * hp + 3), $time - t0);
      end
      tick(40);
      check("far rx", 8'(8'hC5 ^ m), frx);
      check("edges", 8'h08, 8'(fcnt - c0));
      check("rx last", 8'(8'h3A + m), rxl);
      checkb("sck stopped", m[1], sck);
      poke(2);
      poke(3);
    end
    dbl <= 1'h0;
    $display("test_modes done");
  endtask
  task automatic test_master();
    sck_idle_polarity <= 1'h0;
    sck_sample_phase <= 1'h0;
    tx <= 8'h3A;
    set_ctrl(8'hD1);
    reselect();
    put(8'hA5);
    put(8'h5A);
    checkb("collision", 1'h1, st[STAT_WRITE_COLLISION_FLAG]);
    wait_done();
    tick(2);
    checkb("irq", 1'h1, irq);
    check("far rx", 8'hA5, frx);
    check("rx head", 8'h3A, rxd);
    checkb("miso drive", 1'h0, miso_oe);
    checkb("mosi drive", 1'h1, mosi_oe);
    poke(0);
    poke(1);
    check("flags cleared", 8'h00, {6'h0, st[7:6]});
    checkb("irq cleared", 1'h0, irq);
    poke(3);
    set_ctrl(8'hF1);
    put(8'h01);
    wait_done();
    check("lsb first out", 8'h80, frx);
    check("lsb first in", 8'h5C, rxl);
    checkb("select held", 1'h0, ssn);
    checkb("select driven", 1'h1, ssn_oe);
    poke(2);
    checkb("vector clear", 1'h0, st[STAT_DONE]);
    poke(3);
    $display("test_master done");
  endtask
  task automatic test_fault();
    logic [7:0] r;
    set_ctrl(8'hD1);
    sslv <= 1'h1;
    tick(4);
    ss_dir <= 1'h0;
    tick(4);
    checkb("master kept", 1'h1, ctl[CTRL_MASTER]);
    u_far.lead(8'h00, 0, 1'h1, r);
    tick(4);
    checkb("master bit", 1'h0, ctl[CTRL_MASTER]);
    checkb("fault flag", 1'h1, st[STAT_DONE]);
    checkb("sck released", 1'h0, sck_oe);
    poke(2);
    $display("test_fault done");
  endtask
  task automatic test_slave();
    logic [7:0] r;
    {mosi_dir, sck_dir, miso_dir} <= 3'h1;
    set_ctrl(8'hC0);
    checkb("idle miso", 1'h0, miso_oe);
    put(8'h96);
    u_far.lead(8'hFF, 8, 1'h0, r);
    u_far.lead(8'hFF, 3, 1'h1, r);
    tick(4);
    checkb("no byte", 1'h0, st[STAT_DONE]);
    checkb("miso released", 1'h0, miso_oe);
    u_far.lead(8'h5A, 8, 1'h1, r);
    check("slave tx", 8'h96, r);
    tick(4);
    checkb("slave done", 1'h1, st[STAT_DONE]);
    checkb("slave irq", 1'h1, irq);
    put(8'h0F);
    u_far.lead(8'h11, 8, 1'h1, r);
    check("next tx", 8'h0F, r);
    u_far.lead(8'h22, 8, 1'h1, r);
    tick(4);
    check("last rx", 8'h22, rxl);
    check("first held", 8'h5A, rxd);
    poke(3);
    check("second held", 8'h11, rxd);
    poke(3);
    checkb("third lost", 1'h0, rxv);
    $display("test_slave done");
  endtask
  // ********
  // Run
  // ********
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 60000);
    err_total++;
    summarize();
  end
  initial begin
    {rst, cwr, dwr, drd, srd, ack, rrdy, dbl, gate} = 9'h100;
    {cdat, wdat, tx} = '0;
    {mosi_dir, miso_dir, sck_dir, ss_dir} = 4'hB;
    {sslv, sck_idle_polarity, sck_sample_phase} = 3'h4;
    err_total = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    tick(2);
    check("reset control", 8'h00, ctl);
    check("reset status", 8'h00, st);
    test_power();
    test_modes();
    test_master();
    test_fault();
    test_slave();
    summarize();
  end
endmodule
